// >>> design/charger_supervisor.sv
`timescale 1ns/100ps
`include "charger_cfg.svh"
// Overview of operation
// RULE1: Status pin low charging, high after termination
// RULE2: Charging status bit set except during top-off
// RULE3: Interrupt pin low on any unmasked set flag
// RULE4: Interrupt flags clear on read; pin follows
// RULE5: Events during a read are held, loaded after
// RULE6: Masks gate the pin, not the flag
// RULE7: Plug-in reloads both input voltage limits
// RULE8: Current ramps to limits; low input backs off
// RULE9: High-impedance bit or pin stops charge, clears timers
// RULE10: Low battery clears high-impedance bit; such writes ignored
// RULE11: Safety timer starts with charging, two segments
// RULE12: Pre segment below minimum, then fast segment persists
// RULE13: Safety expiry: stop, defaults, idle, flag, status
// RULE14: Continue bit keeps charging after safety expiry
// RULE15: Watchdog enable starts watchdog, pauses safety timer
// RULE16: Restart bit restarts watchdog; host writes it often
// RULE17: Watchdog expiry: defaults except safety, flag, status
// RULE18: Watchdog action bit sends device idle on expiry
// RULE19: Top-off timer expiry stops, battery switch off, flag
// RULE20: Recharge after top-off unless recharge disabled
// RULE21: Die hot: lowest current, step back up, repeat
// RULE22: Input current limits untouched by thermal regulation
// RULE23: Interrupt pin is inverted OR of unmasked flags
module charger_supervisor #(
   parameter int SEC_CYCLES = `SEC_TICK_CYCLES,
   parameter int STEP_CYCLES = `STEP_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire charger_pkg::reg_req_t req,
   input wire charger_pkg::pins_t pins,
   output charger_pkg::reg_rsp_t rsp,
   output logic stat_n,
   output logic int_n,
   output logic charge_en,
   output logic batfet_on,
   output logic [5:0] current_cmd,
   output logic [3:0] primary_input_voltage_limit,
   output logic [3:0] secondary_input_voltage_limit
);
   import charger_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      pins_t s1;                // First synchroniser stage
      pins_t s2;                // Second synchroniser stage
      pins_t prev;              // Delayed copy for edges
      chg_state_t st;           // Charger state
      logic [26:0] sec_div;     // Seconds prescaler
      logic sec_tick;           // One-second enable
      logic [16:0] step_div;    // Current step prescaler
      logic step_tick;          // Current step enable
      logic fast_started;       // Fast segment has begun
      logic [2:0][7:0] flags;   // Interrupt flags
      logic [2:0][7:0] pend;    // Events caught during a read
      logic [2:0][7:0] mask;    // Interrupt masks
      cfg_t cfg;                // Configuration bytes
      logic safe_to;            // Safety timeout status
      logic wd_to;              // Watchdog timeout status
      logic therm;              // Thermal regulation status
      logic chg_cmp;            // Charge complete status
      reg_rsp_t rsp;            // Read answer
      logic stat_n;             // Status pin
      logic int_n;              // Interrupt pin
      logic charge_en;          // Charger enable
      logic batfet_on;          // Battery switch
      logic [5:0] current_cmd;  // Charge current code
   } sup_state_t;

   sup_state_t cur, nx;
   logic pre_run, pre_clr, fc_run, fc_clr, wd_run, wd_clr, to_run, to_clr; // Timer controls
   logic pre_exp, fc_exp, wd_exp, to_exp;  // Timer expiry pulses
   logic [15:0] pre_lim, fc_lim, to_lim;   // Timer limits in seconds
   logic [2:0][7:0] ev;                    // Interrupt events this cycle
   logic [2:0] rd_hit;                     // Read of a flag register
   logic [7:0] rval;                       // Read value
   logic hz_req, wd_en, hot, rd_flag_sel;  // Decoded conditions
   logic [1:0] fsel;                       // Flag register index

   // Defaults for the configuration bytes
   function automatic cfg_t cfg_default();
      cfg_t c;
      c.control = `DEF_CONTROL;
      c.thermal = `DEF_THERMAL;
      c.icharge = `DEF_ICHARGE;
      c.vlim_pri = `DEF_VLIM;
      c.vlim_sec = `DEF_VLIM;
      c.timer = `DEF_TIMER;
      c.safety = `DEF_SAFETY;
      c.topoff = `DEF_TOPOFF;
      c.wdact = `DEF_WDACT;
      return c;
   endfunction

   // ==========================================================
   // Timer limits from the timer and top-off fields
   always_comb begin
      pre_lim = 16'(({14'h0000, cur.cfg.timer[`TMR_PRE_LSB +: 2]} + 16'h0001) * `PRE_UNIT_S);
      fc_lim = 16'(({13'h0000, cur.cfg.timer[`TMR_FC_LSB +: 3]} + 16'h0001) * `FC_UNIT_S);
      to_lim = 16'(({13'h0000, cur.cfg.topoff[2:0]} + 16'h0001) * `TO_UNIT_S); // see RULE19
   end

   // Pre-charge, fast-charge, watchdog and top-off timers
   seg_timer u_pre (.mclk(mclk), .nrst(nrst), .tick(cur.sec_tick), .run(pre_run),
      .clear(pre_clr), .limit(pre_lim), .expired(pre_exp));
   seg_timer u_fc (.mclk(mclk), .nrst(nrst), .tick(cur.sec_tick), .run(fc_run),
      .clear(fc_clr), .limit(fc_lim), .expired(fc_exp));
   seg_timer u_wd (.mclk(mclk), .nrst(nrst), .tick(cur.sec_tick), .run(wd_run),
      .clear(wd_clr), .limit(`WD_PERIOD_S), .expired(wd_exp));
   seg_timer u_to (.mclk(mclk), .nrst(nrst), .tick(cur.sec_tick), .run(to_run),
      .clear(to_clr), .limit(to_lim), .expired(to_exp));

   // ==========================================================
   // Register read decode and read value
   always_comb begin
      fsel = req.addr[1:0];
      rd_flag_sel = req.rd && req.addr >= `REG_IRQ_A && req.addr <= `REG_IRQ_C;
      rd_hit = 3'b000;
      if (rd_flag_sel) begin
         rd_hit[fsel] = 1'b1;
      end
      rval = 8'h00;
      case (req.addr)
         `REG_STATUS0: rval[`STAT_CHARGING_BIT] = (cur.st == ST_CHARGE); // see RULE2
         `REG_STATUS1: rval[`STAT_CHARGE_COMPLETE_STATUS_BIT] = cur.chg_cmp;
         `REG_STATUS2: begin
            rval[`STAT_SAFE_TO_BIT] = cur.safe_to;
            rval[`STAT_WD_TO_BIT] = cur.wd_to;
            rval[`STAT_THERM_BIT] = cur.therm;
         end
         `REG_CONTROL: rval = cur.cfg.control;
         `REG_THERMAL: rval = cur.cfg.thermal;
         `REG_ICHARGE: rval = cur.cfg.icharge;
         `REG_VLIM_PRI: rval = cur.cfg.vlim_pri;
         `REG_VLIM_SEC: rval = cur.cfg.vlim_sec;
         `REG_TIMER: rval = cur.cfg.timer;
         `REG_SAFETY: rval = cur.cfg.safety;
         `REG_TOPOFF: rval = cur.cfg.topoff;
         `REG_WDACT: rval = cur.cfg.wdact;
         default: begin
            // Flag registers include anything still pending
            if (req.addr >= `REG_IRQ_A && req.addr <= `REG_IRQ_C) begin
               rval = cur.flags[fsel] | cur.pend[fsel];
            end else if (req.addr >= `REG_MASK_A && req.addr <= `REG_MASK_C) begin
               rval = cur.mask[fsel];
            end
         end
      endcase
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      nx = cur;
      ev = '0;
      pre_run = 1'b0;
      fc_run = 1'b0;
      wd_run = 1'b0;
      to_run = 1'b0;
      pre_clr = 1'b0;
      fc_clr = 1'b0;
      wd_clr = 1'b0;
      to_clr = 1'b0;
      // Pin synchronisers; only the second stage and its delayed copy are read below
      nx.s1 = pins;
      nx.s2 = cur.s1;
      nx.prev = cur.s2;
      // Slow enables from the system clock
      nx.sec_tick = (cur.sec_div == 27'(SEC_CYCLES - 1));
      nx.sec_div = nx.sec_tick ? 27'h0000000 : cur.sec_div + 27'h0000001;
      nx.step_tick = (cur.step_div == 17'(STEP_CYCLES - 1));
      nx.step_div = nx.step_tick ? 17'h00000 : cur.step_div + 17'h00001;
      // Register writes
      if (req.wr) begin
         case (req.addr)
            `REG_CONTROL: begin
               nx.cfg.control = req.wdata;
               // Entering high impedance is refused on a low battery
               if (cur.s2.vbat_below_min) begin
                  nx.cfg.control[`CTL_HZ_BIT] = 1'b0; // see RULE10
               end
            end
            `REG_THERMAL: nx.cfg.thermal = req.wdata;
            `REG_ICHARGE: nx.cfg.icharge = req.wdata;
            `REG_VLIM_PRI: nx.cfg.vlim_pri = req.wdata;
            `REG_VLIM_SEC: nx.cfg.vlim_sec = req.wdata;
            `REG_TIMER: begin
               // Restart bit acts once and reads back as zero
               nx.cfg.timer = req.wdata;
               nx.cfg.timer[`TMR_RESTART_BIT] = 1'b0;
               wd_clr = req.wdata[`TMR_RESTART_BIT]; // see RULE16
            end
            `REG_SAFETY: nx.cfg.safety = req.wdata;
            `REG_TOPOFF: nx.cfg.topoff = req.wdata;
            `REG_WDACT: nx.cfg.wdact = req.wdata;
            default: begin
               if (req.addr >= `REG_MASK_A && req.addr <= `REG_MASK_C) begin
                  nx.mask[fsel] = req.wdata;
               end
            end
         endcase
      end
      hz_req = cur.cfg.control[`CTL_HZ_BIT] || cur.s2.disable_pin;
      wd_en = cur.cfg.timer[`TMR_WATCHDOG_ENABLE_BIT_BIT];
      hot = cur.s2.die_hot[cur.cfg.thermal[6:5]];
      // Input limits return to defaults when a source appears
      if (cur.s2.source_present && !cur.prev.source_present) begin
         nx.cfg.vlim_pri[3:0] = 4'(`DEF_VLIM); // see RULE7
         nx.cfg.vlim_sec[3:0] = 4'(`DEF_VLIM); // see RULE7
         nx.safe_to = 1'b0;
         nx.wd_to = 1'b0;
         nx.chg_cmp = 1'b0;
      end
      // Safety timer is cleared outside charge and in high impedance
      if (cur.st != ST_CHARGE) begin
         pre_clr = 1'b1; // see RULE9
         fc_clr = 1'b1; // see RULE9
         wd_clr = 1'b1; // see RULE9
         nx.fast_started = 1'b0;
      end
      if (cur.st != ST_TOPOFF) begin
         to_clr = 1'b1;
      end
      // Charger state machine
      case (cur.st)
         ST_SLEEP: begin
            if (cur.s2.source_present) begin
               nx.st = hz_req ? ST_HIZ : ST_CHARGE;
            end
         end
         ST_HIZ: begin
            // Low battery releases the register request
            if (cur.cfg.control[`CTL_HZ_BIT] && cur.s2.vbat_below_min) begin
               nx.cfg.control[`CTL_HZ_BIT] = 1'b0; // see RULE10
            end
            if (!hz_req || (cur.s2.vbat_below_min && !cur.s2.disable_pin)) begin
               nx.st = ST_CHARGE; // see RULE10
            end
         end
         ST_CHARGE: begin
            // Pre segment runs below minimum until fast segment begins
            pre_run = !cur.fast_started && cur.s2.vbat_below_min && !wd_en; // see RULE11
            if (!cur.fast_started && !cur.s2.vbat_below_min) begin
               nx.fast_started = 1'b1; // see RULE12
               pre_clr = 1'b1; // see RULE12
            end
            // Watchdog in use pauses both safety segments
            fc_run = cur.fast_started && !wd_en; // see RULE15
            wd_run = wd_en; // see RULE15
            if (hz_req) begin
               nx.st = ST_HIZ; // see RULE9
            end else if (pre_exp || fc_exp) begin
               ev[2][`IRQ_C_TIMER_BIT] = 1'b1; // see RULE13
               nx.safe_to = 1'b1; // see RULE13
               if (!cur.cfg.control[`CTL_CONTINUE_ON_EXPIRY_BIT_BIT]) begin
                  nx.cfg = cfg_default(); // see RULE13
                  nx.st = ST_IDLE; // see RULE13
               end // Otherwise charging carries on, see RULE14
            end else if (wd_exp) begin
               ev[2][`IRQ_C_TIMER_BIT] = 1'b1; // see RULE17
               nx.wd_to = 1'b1; // see RULE17
               nx.cfg = cfg_default(); // see RULE17
               nx.cfg.safety = cur.cfg.safety; // see RULE17
               if (cur.cfg.wdact[`WDACT_BIT]) begin
                  nx.st = ST_IDLE; // see RULE18
               end
            end else if (cur.s2.term_done && !cur.prev.term_done) begin
               ev[0][`IRQ_A_CHGEND_BIT] = 1'b1;
               nx.chg_cmp = !cur.cfg.control[`CTL_TOEN_BIT];
               nx.st = cur.cfg.control[`CTL_TOEN_BIT] ? ST_TOPOFF : ST_DONE; // see RULE1
            end
         end
         ST_TOPOFF: begin
            to_run = 1'b1; // see RULE19
            if (hz_req) begin
               nx.st = ST_HIZ;
            end else if (to_exp) begin
               ev[2][`IRQ_C_TOPOFF_COMPLETE_IRQ_BIT] = 1'b1; // see RULE19
               nx.chg_cmp = 1'b1;
               nx.st = ST_DONE; // see RULE19
            end
         end
         ST_DONE: begin
            if (hz_req) begin
               nx.st = ST_HIZ;
            end else if (!cur.cfg.control[`CTL_RECHARGE_DISABLE_BIT_BIT] && cur.s2.vbat_below_recharge) begin
               nx.chg_cmp = 1'b0;
               nx.st = ST_CHARGE; // see RULE20
            end
         end
         ST_IDLE: nx.st = ST_IDLE;
         default: nx.st = ST_SLEEP;
      endcase
      // Source loss always ends in sleep
      if (!cur.s2.source_present) begin
         nx.st = ST_SLEEP;
      end
      // Charge current: thermal fold-back and input voltage loop
      nx.therm = 1'b0;
      if (cur.st != ST_CHARGE && cur.st != ST_TOPOFF) begin
         nx.current_cmd = `ICHG_LOWEST;
      end else if (hot) begin
         nx.current_cmd = `ICHG_LOWEST; // see RULE21
         nx.therm = 1'b1;
         ev[2][`IRQ_C_THERM_BIT] = !cur.therm; // see RULE21
      end else if (cur.step_tick) begin
         // Only the charge current moves; input current limits stay, see RULE22
         if (cur.s2.vsrc_below_limit && cur.current_cmd != `ICHG_LOWEST) begin
            nx.current_cmd = cur.current_cmd - 6'h01; // see RULE8
         end else if (cur.current_cmd > cur.cfg.icharge[5:0]) begin
            nx.current_cmd = cur.cfg.icharge[5:0];
         end else if (!cur.s2.vsrc_below_limit && !cur.s2.at_input_ilim
                      && cur.current_cmd < cur.cfg.icharge[5:0]) begin
            nx.current_cmd = cur.current_cmd + 6'h01; // see RULE8, RULE21
         end
      end
      // Flags: read clears, events during a read wait one cycle
      for (int i = 0; i < 3; i++) begin
         if (rd_hit[i]) begin
            nx.flags[i] = 8'h00; // see RULE4
            nx.pend[i] = ev[i]; // see RULE5
         end else begin
            nx.flags[i] = cur.flags[i] | cur.pend[i] | ev[i]; // see RULE5, RULE6
            nx.pend[i] = 8'h00;
         end
      end
      // Pin outputs
      nx.int_n = ~|((nx.flags | nx.pend) & ~nx.mask); // see RULE3, RULE5, RULE6, RULE23
      nx.stat_n = (nx.st != ST_CHARGE); // see RULE1
      nx.charge_en = (nx.st == ST_CHARGE || nx.st == ST_TOPOFF);
      nx.batfet_on = (nx.st != ST_DONE && nx.st != ST_IDLE); // see RULE19
      nx.rsp.rvalid = req.rd;
      nx.rsp.rdata = req.rd ? rval : 8'h00;
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         cur.st <= ST_SLEEP;
         cur.cfg <= cfg_default();
         cur.mask <= {3{`DEF_MASK}};
         cur.stat_n <= 1'b1;
         cur.int_n <= 1'b1;
         cur.batfet_on <= 1'b1;
      end else begin
         cur <= nx;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   assign rsp = cur.rsp;
   assign stat_n = cur.stat_n;
   assign int_n = cur.int_n;
   assign charge_en = cur.charge_en;
   assign batfet_on = cur.batfet_on;
   assign current_cmd = cur.current_cmd;
   assign primary_input_voltage_limit = cur.cfg.vlim_pri[3:0];
   assign secondary_input_voltage_limit = cur.cfg.vlim_sec[3:0];
endmodule // charger_supervisor

// >>> inc/charger_cfg.svh
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH
// ==========================================================
// Clock and time bases
`define CLK_PERIOD_NS 10
`define SEC_TICK_MS 1000
`define SEC_TICK_CYCLES (`SEC_TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define STEP_TIME_US 1000
`define STEP_CYCLES (`STEP_TIME_US * 1000 / `CLK_PERIOD_NS)
// ==========================================================
// Timer lengths in seconds
`define PRE_UNIT_S 16'h0258
`define FC_UNIT_S 16'h0E10
`define WD_PERIOD_S 16'h0020
`define TO_UNIT_S 16'h0258
// ==========================================================
// Register offsets
`define REG_STATUS0 8'h00
`define REG_STATUS1 8'h01
`define REG_STATUS2 8'h02
`define REG_IRQ_A 8'h04
`define REG_IRQ_C 8'h06
`define REG_MASK_A 8'h08
`define REG_MASK_C 8'h0A
`define REG_CONTROL 8'h0E
`define REG_THERMAL 8'h0F
`define REG_ICHARGE 8'h12
`define REG_VLIM_PRI 8'h15
`define REG_VLIM_SEC 8'h17
`define REG_TIMER 8'h19
`define REG_SAFETY 8'h1A
`define REG_TOPOFF 8'h1B
`define REG_WDACT 8'h30
// ==========================================================
// Field positions
`define STAT_CHARGING_BIT 3
`define STAT_CHARGE_COMPLETE_STATUS_BIT 4
`define STAT_SAFE_TO_BIT 0
`define STAT_WD_TO_BIT 1
`define STAT_THERM_BIT 4
`define CTL_HZ_BIT 1
`define CTL_TOEN_BIT 2
`define CTL_RECHARGE_DISABLE_BIT_BIT 5
`define CTL_CONTINUE_ON_EXPIRY_BIT_BIT 7
`define TMR_PRE_LSB 0
`define TMR_FC_LSB 2
`define TMR_WATCHDOG_ENABLE_BIT_BIT 6
`define TMR_RESTART_BIT 7
`define WDACT_BIT 7
`define IRQ_A_CHGEND_BIT 3
`define IRQ_C_TIMER_BIT 0
`define IRQ_C_THERM_BIT 4
`define IRQ_C_TOPOFF_COMPLETE_IRQ_BIT 7
// ==========================================================
// Reset values
`define DEF_CONTROL 8'h08
`define DEF_THERMAL 8'h60
`define DEF_ICHARGE 8'h0A
`define DEF_VLIM 8'h05
`define DEF_TIMER 8'h0F
`define DEF_SAFETY 8'h7F
`define DEF_TOPOFF 8'h03
`define DEF_WDACT 8'h00
`define DEF_MASK 8'h00
`define ICHG_LOWEST 6'h00
`endif

// >>> inc/charger_pkg.sv
package charger_pkg;
   // Charger operating states
   typedef enum logic [2:0] {ST_SLEEP, ST_CHARGE, ST_TOPOFF, ST_DONE, ST_HIZ, ST_IDLE}
      chg_state_t;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;
   // Register port answer
   typedef struct packed {
      logic rvalid;
      logic [7:0] rdata;
   } reg_rsp_t;
   // Pin and analog comparator inputs
   typedef struct packed {
      logic disable_pin;
      logic source_present;
      logic vbat_below_min;
      logic vbat_below_recharge;
      logic term_done;
      logic [3:0] die_hot;
      logic vsrc_below_limit;
      logic at_input_ilim;
   } pins_t;
   // Writable configuration bytes
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] thermal;
      logic [7:0] icharge;
      logic [7:0] vlim_pri;
      logic [7:0] vlim_sec;
      logic [7:0] timer;
      logic [7:0] safety;
      logic [7:0] topoff;
      logic [7:0] wdact;
   } cfg_t;
   // Segment timer state
   typedef struct packed {
      logic [15:0] count;
      logic expired;
   } seg_timer_t;
endpackage

// >>> design/seg_timer.sv
`timescale 1ns/100ps
// ==========================================================
// Seconds counter that pulses once on reaching its limit
module seg_timer (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [15:0] limit,
   output logic expired
);
   import charger_pkg::*;
   charger_pkg::seg_timer_t cur, nx; // State and next state

   // Count while running, saturate at the limit so expiry fires once
   always_comb begin
      nx = cur;
      nx.expired = 1'b0;
      if (clear) begin
         nx.count = 16'h0000;
      end else if (run && tick && cur.count < limit) begin
         nx.count = cur.count + 16'h0001;
         nx.expired = (nx.count == limit);
      end
   end

   // State register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= nx;
      end
   end

   assign expired = cur.expired;
endmodule // seg_timer

// >>> tb/charger_supervisor_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port-level checks of the supervisor
module charger_supervisor_assertions #(
   parameter int SEC_CYCLES = 10,
   parameter int STEP_CYCLES = 4
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire charger_pkg::reg_req_t req,
   input wire charger_pkg::pins_t pins,
   input wire charger_pkg::reg_rsp_t rsp,
   input wire logic stat_n,
   input wire logic int_n,
   input wire logic charge_en,
   input wire logic batfet_on,
   input wire logic [5:0] current_cmd,
   input wire logic [3:0] primary_input_voltage_limit,
   input wire logic [3:0] secondary_input_voltage_limit
);
   import charger_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Disable pin held past the synchroniser
   sequence s_dis_held;
      pins.disable_pin [*5];
   endsequence
   // Both limits back at their defaults
   sequence s_lim_def;
      primary_input_voltage_limit == 4'h5 && secondary_input_voltage_limit == 4'h5;
   endsequence
   property p_dis;
      s_dis_held |-> !charge_en;
   endproperty
   a_dis: assert property (p_dis) else $error("charging with disable pin high");
   property p_plug;
      $rose(pins.source_present) |-> ##[1:6] s_lim_def;
   endproperty
   a_plug: assert property (p_plug) else $error("limits not reloaded");
   property p_stat;
      !stat_n |-> charge_en;
   endproperty
   a_stat: assert property (p_stat) else $error("status low while idle");
   property p_term;
      $rose(pins.term_done) |-> ##[1:6] stat_n;
   endproperty
   a_term: assert property (p_term) else $error("status low after end");
   property p_read;
      rsp.rvalid && $past(req.addr) == 8'h00 |-> rsp.rdata[3] == !$past(stat_n);
   endproperty
   a_read: assert property (p_read) else $error("charging bit wrong");
   property p_irq;
      $rose(int_n) |-> rsp.rvalid || $past(req.wr) || $past(req.wr, 2) || $past(req.wr, 3);
   endproperty
   a_irq: assert property (p_irq) else $error("int released without read");
   property p_fet;
      !batfet_on |-> !charge_en;
   endproperty
   a_fet: assert property (p_fet) else $error("charging with switch off");
   property p_ramp;
      current_cmd > $past(current_cmd) |-> current_cmd == $past(current_cmd) + 6'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("current jumped up");
endmodule // charger_supervisor_assertions
bind charger_supervisor charger_supervisor_assertions #(
   .SEC_CYCLES(SEC_CYCLES), .STEP_CYCLES(STEP_CYCLES)) u_chk (
   .mclk(mclk), .nrst(nrst), .req(req), .pins(pins), .rsp(rsp), .stat_n(stat_n),
   .int_n(int_n), .charge_en(charge_en), .batfet_on(batfet_on), .current_cmd(current_cmd),
   .primary_input_voltage_limit(primary_input_voltage_limit),
   .secondary_input_voltage_limit(secondary_input_voltage_limit));

// >>> tb/host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host processor on the register port
module host_model (
   input wire logic mclk,
   output charger_pkg::reg_req_t req,
   input wire charger_pkg::reg_rsp_t rsp
);
   import charger_pkg::*;
   initial req = '0;
   // One-cycle write strobe; timer restart kicks go through here
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(negedge mclk);
      req = '0;
   endtask
   // One-cycle read strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk);
      req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge mclk);
      req = '0;
      v = rsp.rvalid ? rsp.rdata : 8'hXX;
   endtask
endmodule // host_model

// >>> tb/test_charger_supervisor.sv
`timescale 1ns/100ps
// ==========================================
// Self-checking bench of the supervisor
module test_charger_supervisor;
   import charger_pkg::*;
   typedef struct packed {logic [7:0] a, def, wd, exp;} row_t;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   pins_t pins = '0;
   reg_req_t req;
   reg_rsp_t rsp;
   logic stat_n, int_n, charge_en, batfet_on;
   logic [5:0] current_cmd;
   logic [3:0] vlim_pri, vlim_sec;
   logic [7:0] d;
   int num_errors = 0;
   int num_checks = 0;
   // Offset, reset value, write data, read-back
   row_t rows [8] = '{'{8'h0F, 8'h60, 8'h40, 8'h40}, '{8'h12, 8'h0A, 8'h0A, 8'h0A},
      '{8'h19, 8'h0F, 8'h8C, 8'h0C}, '{8'h1A, 8'h7F, 8'h55, 8'h55},
      '{8'h1B, 8'h03, 8'h00, 8'h00}, '{8'h30, 8'h00, 8'h80, 8'h80},
      '{8'h09, 8'h00, 8'hFF, 8'hFF}, '{8'h3F, 8'h00, 8'hAA, 8'h00}};
   charger_supervisor #(.SEC_CYCLES(10), .STEP_CYCLES(4)) u_charger_supervisor (
      .mclk(mclk), .nrst(nrst), .req(req), .pins(pins), .rsp(rsp), .stat_n(stat_n),
      .int_n(int_n), .charge_en(charge_en), .batfet_on(batfet_on), .current_cmd(current_cmd),
      .primary_input_voltage_limit(vlim_pri), .secondary_input_voltage_limit(vlim_sec));
   host_model u_host_model (.mclk(mclk), .req(req), .rsp(rsp));
   initial forever #5 mclk = ~mclk;
   // ==========================================
   // Helpers
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      u_host_model.rd(a, d);
      chk($sformatf("reg %h", a), d & m, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wait_idle(input int lim);
      while (charge_en !== 1'b0 && lim > 0) begin
         @(negedge mclk);
         lim--;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #1000000;
      num_errors++;
      end_of_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      cyc(4);
      chk("reset pins", {4'h0, stat_n, int_n, charge_en, batfet_on}, 8'h0D);
      nrst = 1'b1;
      foreach (rows[i]) begin
         rc(rows[i].a, 8'hFF, rows[i].def);
         u_host_model.wr(rows[i].a, rows[i].wd);
         rc(rows[i].a, 8'hFF, rows[i].exp);
      end
      $display("test registers done");
      u_host_model.wr(8'h15, 8'h0C);
      u_host_model.wr(8'h17, 8'h0C);
      chk("vlim set", {vlim_pri, vlim_sec}, 8'hCC);
      pins.source_present = 1'b1;
      cyc(60);
      chk("vlim plug", {vlim_pri, vlim_sec}, 8'h55);
      chk("stat_n", 8'(stat_n), 8'h00);
      rc(8'h00, 8'h08, 8'h08);
      chk("ramp", 8'(current_cmd), 8'h0A);
      pins.vsrc_below_limit = 1'b1;
      cyc(12);
      chk("back off", 8'(current_cmd < 6'h0A), 8'h01);
      pins.vsrc_below_limit = 1'b0;
      cyc(60);
      $display("test plug-in done");
      pins.die_hot = 4'h4;
      cyc(1);
      rc(8'h06, 8'h10, 8'h00);
      chk("thermal", 8'(current_cmd < 6'h02), 8'h01);
      chk("int low", 8'(int_n), 8'h00);
      rc(8'h06, 8'h10, 8'h10);
      chk("int high", 8'(int_n), 8'h01);
      pins.die_hot = 4'h0;
      cyc(60);
      chk("step up", 8'(current_cmd), 8'h0A);
      chk("vlim kept", {vlim_pri, vlim_sec}, 8'h55);
      $display("test thermal done");
      u_host_model.wr(8'h08, 8'h08);
      u_host_model.wr(8'h0E, 8'h0C);
      pins.term_done = 1'b1;
      cyc(10);
      chk("masked", {4'h0, int_n, stat_n, charge_en, batfet_on}, 8'h0F);
      rc(8'h00, 8'h08, 8'h00);
      rc(8'h04, 8'h08, 8'h08);
      rc(8'h04, 8'h08, 8'h00);
      wait_idle(7000);
      chk("topoff end", {4'h0, int_n, charge_en, batfet_on, stat_n}, 8'h01);
      rc(8'h06, 8'h80, 8'h80);
      chk("int clear", 8'(int_n), 8'h01);
      pins.term_done = 1'b0;
      pins.vbat_below_recharge = 1'b1;
      cyc(8);
      chk("recharge", 8'(charge_en), 8'h01);
      pins.vbat_below_recharge = 1'b0;
      $display("test top-off done");
      u_host_model.wr(8'h0E, 8'h0A);
      cyc(6);
      chk("hiz", 8'(charge_en), 8'h00);
      pins.vbat_below_min = 1'b1;
      cyc(8);
      chk("hiz exit", 8'(charge_en), 8'h01);
      rc(8'h0E, 8'h02, 8'h00);
      u_host_model.wr(8'h0E, 8'h0A);
      rc(8'h0E, 8'h02, 8'h00);
      pins.disable_pin = 1'b1;
      cyc(8);
      chk("disable", 8'(charge_en), 8'h00);
      pins.disable_pin = 1'b0;
      pins.vbat_below_min = 1'b0;
      cyc(8);
      $display("test high impedance done");
      u_host_model.wr(8'h30, 8'h80);
      u_host_model.wr(8'h19, 8'h4F);
      wait_idle(500);
      chk("wd idle", {6'h00, charge_en, batfet_on}, 8'h00);
      rc(8'h02, 8'h02, 8'h02);
      rc(8'h06, 8'h01, 8'h01);
      $display("test watchdog done");
      end_of_test();
   end
endmodule // test_charger_supervisor
